/* stp_pkg.sv */
package stp_pkg;

  // Instruction register width and codes
  localparam int unsigned IR_W = 4;
  localparam logic [3:0] IR_RESET_VAL = 4'h1;
  localparam logic [3:0] INS_BYPASS = 4'hf;
  localparam logic [3:0] INS_IDCODE = 4'h1;
  localparam logic [3:0] INS_EMUCFG = 4'h2;

  // Data register widths
  localparam int unsigned ID_W = 32;
  localparam int unsigned CFG_W = 4;

  // Arbitrary identification value
  localparam logic [31:0] ID_VAL = 32'h00000001;

  // Emulation configuration after reset: both event pins inputs
  localparam logic [3:0] CFG_RESET_VAL = 4'h0;

  // Standard sixteen-state test access port controller
  typedef enum logic [3:0] {
    ST_RESET  = 4'h0,
    ST_IDLE   = 4'h1,
    ST_SEL_DR = 4'h2,
    ST_CAP_DR = 4'h3,
    ST_SH_DR  = 4'h4,
    ST_EX1_DR = 4'h5,
    ST_PA_DR  = 4'h6,
    ST_EX2_DR = 4'h7,
    ST_UP_DR  = 4'h8,
    ST_SEL_IR = 4'h9,
    ST_CAP_IR = 4'ha,
    ST_SH_IR  = 4'hb,
    ST_EX1_IR = 4'hc,
    ST_PA_IR  = 4'hd,
    ST_EX2_IR = 4'he,
    ST_UP_IR  = 4'hf
  } stp_state_t;

  // Test port pins after synchronisation
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst;
  } stp_pins_t;

endpackage

/* stp_sync.sv */
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser bank for slow pins
module stp_sync #(
  parameter int unsigned W = 4
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // First stage feeds only the second stage
  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  // Register both stages; reset to zero keeps scan in functional mode
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule

`default_nettype wire

/* stp_scan_port.sv */
`timescale 1ns/10ps
`default_nettype none

// Operation
// R1: Test reset high gives scan control
// R2: Test reset low ignores scan inputs
// R3: Sample mode and data on rising test clock
// R4: Change data output on falling test clock
// R5: Data output floats unless shifting
// R6: Event zero bidirectional, direction via scan
// R7: Event one bidirectional, direction via scan
// R8: Test reset low: event one is disable
// R9: Disable needs reset 0, zero 1, one 0
// R10: Disable floats every output driver
// R11: Disable only for test, not sharing
// R12: Timer, transmit data, frame also float
// R13: Standard sixteen-state controller and registers
module stp_scan_port (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_i,
  output logic tdo_o,
  output logic tdo_oe_n_o,
  input wire logic emulator_event_zero_i,
  output logic emulator_event_zero_o,
  output logic emulator_event_zero_oe_n_o,
  input wire logic emulator_event_one_or_disable_i,
  output logic emulator_event_one_or_disable_o,
  output logic emulator_event_one_or_disable_oe_n_o,
  input wire logic core_event_zero_i,
  input wire logic core_event_one_i,
  output logic emu_event_zero_o,
  output logic emu_event_one_o,
  output logic scan_control_o,
  output logic outputs_off_o,
  input wire logic timer_pulse_i,
  input wire logic ser_tx_data_i,
  input wire logic ser_tx_frame_i,
  input wire logic ser_tx_frame_oe_n_i,
  output logic timer_pulse_out_o,
  output logic timer_pulse_out_oe_n_o,
  output logic ser_tx_data_o,
  output logic ser_tx_data_oe_n_o,
  output logic ser_tx_frame_o,
  output logic ser_tx_frame_oe_n_o
);

  // Synchronised pins, including both emulator lines
  stp_pkg::stp_pins_t pins;
  logic [1:0] emu_s;
  logic [5:0] sync_out;

  stp_sync #(
    .W(6)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({emulator_event_one_or_disable_i, emulator_event_zero_i,
              tck_i, tms_i, tdi_i, trst_i}),
    .sync_o(sync_out)
  );

  assign pins = sync_out[3:0];
  assign emu_s = sync_out[5:4];

  // Controller, registers and edge tracking
  stp_pkg::stp_state_t st_q, st_d;
  logic tck_q, tck_d;
  logic [3:0] ir_q, ir_d;
  logic [3:0] ir_sh_q, ir_sh_d;
  logic [31:0] dr_sh_q, dr_sh_d;
  logic [3:0] cfg_q, cfg_d;
  logic tdo_q, tdo_d;
  logic tdo_en_q, tdo_en_d;
  logic rise, fall;
  logic shifting;
  logic off_cond;

  // Edges are found from the sampled test clock, so the test clock
  // must stay well below a quarter of the system clock rate
  assign rise = pins.tck & ~tck_q;
  assign fall = ~pins.tck & tck_q;
  assign shifting = (st_q == stp_pkg::ST_SH_DR) ||
                    (st_q == stp_pkg::ST_SH_IR);

  // Next-state logic of the scan engine
  always_comb begin
    st_d = st_q;
    tck_d = pins.tck;
    ir_d = ir_q;
    ir_sh_d = ir_sh_q;
    dr_sh_d = dr_sh_q;
    cfg_d = cfg_q;
    tdo_d = tdo_q;
    tdo_en_d = tdo_en_q;
    if (!pins.trst) begin
      // Functional mode: scan inputs ignored, engine held in reset
      st_d = stp_pkg::ST_RESET; // R2
      ir_d = stp_pkg::IR_RESET_VAL;
      cfg_d = stp_pkg::CFG_RESET_VAL;
      tdo_en_d = 1'b0;
    end else if (rise) begin
      // Inputs are taken only on the rising test clock
      if (shifting) begin
        if (st_q == stp_pkg::ST_SH_IR) begin
          ir_sh_d = {pins.tdi, ir_sh_q[3:1]}; // R3
        end else if (ir_q == stp_pkg::INS_IDCODE) begin
          dr_sh_d = {pins.tdi, dr_sh_q[31:1]}; // R3
        end else if (ir_q == stp_pkg::INS_EMUCFG) begin
          dr_sh_d = {28'h0000000, pins.tdi, dr_sh_q[3:1]};
        end else begin
          dr_sh_d = {31'h00000000, pins.tdi};
        end
      end
      case (st_q) // R13
        stp_pkg::ST_RESET: begin
          st_d = pins.tms ? stp_pkg::ST_RESET : stp_pkg::ST_IDLE;
          ir_d = stp_pkg::IR_RESET_VAL;
        end
        stp_pkg::ST_IDLE:
          st_d = pins.tms ? stp_pkg::ST_SEL_DR : stp_pkg::ST_IDLE;
        stp_pkg::ST_SEL_DR:
          st_d = pins.tms ? stp_pkg::ST_SEL_IR : stp_pkg::ST_CAP_DR;
        stp_pkg::ST_CAP_DR: begin
          st_d = pins.tms ? stp_pkg::ST_EX1_DR : stp_pkg::ST_SH_DR;
          if (ir_q == stp_pkg::INS_IDCODE) begin
            dr_sh_d = stp_pkg::ID_VAL;
          end else if (ir_q == stp_pkg::INS_EMUCFG) begin
            dr_sh_d = {28'h0000000, cfg_q};
          end else begin
            dr_sh_d = 32'h00000000;
          end
        end
        stp_pkg::ST_SH_DR:
          st_d = pins.tms ? stp_pkg::ST_EX1_DR : stp_pkg::ST_SH_DR;
        stp_pkg::ST_EX1_DR:
          st_d = pins.tms ? stp_pkg::ST_UP_DR : stp_pkg::ST_PA_DR;
        stp_pkg::ST_PA_DR:
          st_d = pins.tms ? stp_pkg::ST_EX2_DR : stp_pkg::ST_PA_DR;
        stp_pkg::ST_EX2_DR:
          st_d = pins.tms ? stp_pkg::ST_UP_DR : stp_pkg::ST_SH_DR;
        stp_pkg::ST_UP_DR: begin
          st_d = pins.tms ? stp_pkg::ST_SEL_DR : stp_pkg::ST_IDLE;
          if (ir_q == stp_pkg::INS_EMUCFG) begin
            cfg_d = dr_sh_q[3:0]; // R6
          end
        end
        stp_pkg::ST_SEL_IR:
          st_d = pins.tms ? stp_pkg::ST_RESET : stp_pkg::ST_CAP_IR;
        stp_pkg::ST_CAP_IR: begin
          st_d = pins.tms ? stp_pkg::ST_EX1_IR : stp_pkg::ST_SH_IR;
          ir_sh_d = stp_pkg::IR_RESET_VAL;
        end
        stp_pkg::ST_SH_IR:
          st_d = pins.tms ? stp_pkg::ST_EX1_IR : stp_pkg::ST_SH_IR;
        stp_pkg::ST_EX1_IR:
          st_d = pins.tms ? stp_pkg::ST_UP_IR : stp_pkg::ST_PA_IR;
        stp_pkg::ST_PA_IR:
          st_d = pins.tms ? stp_pkg::ST_EX2_IR : stp_pkg::ST_PA_IR;
        stp_pkg::ST_EX2_IR:
          st_d = pins.tms ? stp_pkg::ST_UP_IR : stp_pkg::ST_SH_IR;
        stp_pkg::ST_UP_IR: begin
          st_d = pins.tms ? stp_pkg::ST_SEL_DR : stp_pkg::ST_IDLE;
          ir_d = ir_sh_q;
        end
        default:
          st_d = stp_pkg::ST_RESET;
      endcase
    end else if (fall) begin
      // Output changes only on the falling test clock
      tdo_en_d = shifting; // R5
      if (st_q == stp_pkg::ST_SH_IR) begin
        tdo_d = ir_sh_q[0]; // R4
      end else begin
        tdo_d = dr_sh_q[0]; // R4
      end
    end
  end

  // Register the scan engine
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_q <= stp_pkg::ST_RESET;
      tck_q <= 1'b0;
      ir_q <= stp_pkg::IR_RESET_VAL;
      ir_sh_q <= stp_pkg::IR_RESET_VAL;
      dr_sh_q <= 32'h00000000;
      cfg_q <= stp_pkg::CFG_RESET_VAL;
      tdo_q <= 1'b0;
      tdo_en_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tck_q <= tck_d;
      ir_q <= ir_d;
      ir_sh_q <= ir_sh_d;
      dr_sh_q <= dr_sh_d;
      cfg_q <= cfg_d;
      tdo_q <= tdo_d;
      tdo_en_q <= tdo_en_d;
    end
  end

  // Disable condition: reset low, event zero high, event one low.
  // Meant for test only; bus sharing must not lean on it.
  assign off_cond = ~pins.trst & emu_s[0] & ~emu_s[1]; // R9 R8 R11

  // Scan control status toward the core
  assign scan_control_o = pins.trst; // R1
  assign outputs_off_o = off_cond; // R10

  // Test data pin, floats when not shifting or when disabled
  assign tdo_o = tdo_q;
  assign tdo_oe_n_o = ~(tdo_en_q & pins.trst) | off_cond; // R5

  // Emulator event lines: cfg bit 0/1 set pin direction (1 = drive),
  // bits 2/3 are the driven level merged with core events
  assign emulator_event_zero_o = cfg_q[2] | core_event_zero_i;
  assign emulator_event_zero_oe_n_o = ~(pins.trst & cfg_q[0]); // R6
  assign emulator_event_one_or_disable_o = cfg_q[3] | core_event_one_i;
  // Low reset turns event one into the disable input
  assign emulator_event_one_or_disable_oe_n_o =
    ~(pins.trst & cfg_q[1]); // R7 R8
  assign emu_event_zero_o = pins.trst & ~cfg_q[0] & emu_s[0]; // R6
  assign emu_event_one_o = pins.trst & ~cfg_q[1] & emu_s[1]; // R7

  // Peripheral outputs float under the disable condition
  assign timer_pulse_out_o = timer_pulse_i;
  assign timer_pulse_out_oe_n_o = off_cond; // R12
  assign ser_tx_data_o = ser_tx_data_i;
  assign ser_tx_data_oe_n_o = off_cond; // R12
  assign ser_tx_frame_o = ser_tx_frame_i;
  assign ser_tx_frame_oe_n_o = ser_tx_frame_oe_n_i | off_cond; // R12 R10

endmodule

`default_nettype wire

/* stp_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// Pin-level checks; pins pass a synchroniser, so most wait on stable pins
module stp_chk (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic tck_i,
  input wire logic trst_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_n_o,
  input wire logic emulator_event_zero_i,
  input wire logic emulator_event_zero_oe_n_o,
  input wire logic emu_event_zero_o,
  input wire logic emulator_event_one_or_disable_i,
  input wire logic emulator_event_one_or_disable_oe_n_o,
  input wire logic scan_control_o,
  input wire logic outputs_off_o,
  input wire logic timer_pulse_i,
  input wire logic timer_pulse_out_o,
  input wire logic timer_pulse_out_oe_n_o,
  input wire logic ser_tx_data_oe_n_o,
  input wire logic ser_tx_frame_oe_n_o
);
  // One domain only
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_scan_follow: assert property (
    $stable(trst_i) [*5] |-> scan_control_o == trst_i)
    else $error("scan control lags test reset");
  a_tdo_float: assert property (
    !trst_i [*4] |-> tdo_oe_n_o) else $error("tdo driven in reset");
  a_tdo_on_fall: assert property (
    $rose(tck_i) |-> ##2 $stable(tdo_o) [*3])
    else $error("tdo moved after tck rise");
  a_off_cond: assert property (
    ($stable(trst_i) && $stable(emulator_event_zero_i)
    && $stable(emulator_event_one_or_disable_i)) [*5] |->
    outputs_off_o == (!trst_i && emulator_event_zero_i
    && !emulator_event_one_or_disable_i))
    else $error("disable condition wrong");
  a_off_floats: assert property (
    outputs_off_o [*2] |-> timer_pulse_out_oe_n_o && ser_tx_data_oe_n_o
    && ser_tx_frame_oe_n_o && tdo_oe_n_o && emulator_event_zero_oe_n_o)
    else $error("driver on while disabled");
  a_ev1_disable: assert property (
    !trst_i [*4] |-> emulator_event_one_or_disable_oe_n_o)
    else $error("event one driven in reset");
  a_ev0_receive: assert property (
    (trst_i && emulator_event_zero_oe_n_o
    && $stable(emulator_event_zero_i)) [*5] |->
    emu_event_zero_o == emulator_event_zero_i)
    else $error("event zero not received");
  a_pass_thru: assert property (
    (!outputs_off_o && $stable(timer_pulse_i)) [*2] |->
    !timer_pulse_out_oe_n_o && timer_pulse_out_o == timer_pulse_i)
    else $error("timer output not passed");
endmodule
bind stp_scan_port stp_chk chk_u (
  .sys_clk_i(sys_clk_i),
  .sys_rst_i(sys_rst_i),
  .tck_i(tck_i),
  .trst_i(trst_i),
  .tdo_o(tdo_o),
  .tdo_oe_n_o(tdo_oe_n_o),
  .emulator_event_zero_i(emulator_event_zero_i),
  .emulator_event_zero_oe_n_o(emulator_event_zero_oe_n_o),
  .emu_event_zero_o(emu_event_zero_o),
  .emulator_event_one_or_disable_i(emulator_event_one_or_disable_i),
  .emulator_event_one_or_disable_oe_n_o(
    emulator_event_one_or_disable_oe_n_o),
  .scan_control_o(scan_control_o),
  .outputs_off_o(outputs_off_o),
  .timer_pulse_i(timer_pulse_i),
  .timer_pulse_out_o(timer_pulse_out_o),
  .timer_pulse_out_oe_n_o(timer_pulse_out_oe_n_o),
  .ser_tx_data_oe_n_o(ser_tx_data_oe_n_o),
  .ser_tx_frame_oe_n_o(ser_tx_frame_oe_n_o)
);
`default_nettype wire

/* stp_emu_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Scan controller model; tck stands low between ticks
module stp_emu_model (
  input wire logic sys_clk_i,
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  logic bit_q;  // Last value seen on tdo
  event seen;  // Fires once per sampled bit
  // Idle levels at time zero
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // One 160 ns tck cycle: inputs change while tck is low
  task automatic tick(input logic m, input logic d, output logic q);
    tms_o <= m;
    tdi_o <= d;
    repeat (4) @(posedge sys_clk_i);
    // Sample late in the low phase so the fall has settled
    @(negedge sys_clk_i) q = tdo_i;
    bit_q = q;
    -> seen;
    @(posedge sys_clk_i) tck_o <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    tck_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
  $display("ERROR %0t %h %h", $time, a, e); end end
module tb;
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, trst = 1'b0, e0_tb = 1'b0;
  logic e1_tb = 1'b1, tp = 1'b0, sd = 1'b0, sf = 1'b0, sfo = 1'b0, ev;
  logic ce0 = 1'b0, ce1 = 1'b0;  // Core event levels
  logic [31:0] r;
  logic [3:0] cfg;
  logic exp_q[$];  // Expected tdo bits, oldest first
  int fails = 0, checks = 0;
  wire logic tck, tms, tdi, tdo, tdo_oe_n, e0_o, e0_oe_n, e1_o, e1_oe_n;
  wire logic off, tpo_oe_n, ev0_rx;
  wire logic ev1_rx, scan_ctl, tpo, sdo, sdo_oe_n, sfr, sfr_oe_n;
  // Pins resolve from both drivers; a floating tdo reads z and never matches
  wire logic e0 = e0_oe_n ? e0_tb : e0_o;
  wire logic e1 = e1_oe_n ? e1_tb : e1_o;
  wire logic tdo_w = tdo_oe_n ? 1'bz : tdo;
  always #10 sys_clk_i = ~sys_clk_i;
  stp_emu_model emu_u (.sys_clk_i(sys_clk_i), .tdo_i(tdo_w), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi));
  stp_scan_port dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_i(trst), .tdo_o(tdo),
    .tdo_oe_n_o(tdo_oe_n), .emulator_event_zero_i(e0),
    .emulator_event_zero_o(e0_o), .emulator_event_zero_oe_n_o(e0_oe_n),
    .emulator_event_one_or_disable_i(e1),
    .emulator_event_one_or_disable_o(e1_o),
    .emulator_event_one_or_disable_oe_n_o(e1_oe_n),
    .core_event_zero_i(ce0), .core_event_one_i(ce1),
    .emu_event_zero_o(ev0_rx), .emu_event_one_o(ev1_rx),
    .scan_control_o(scan_ctl),
    .outputs_off_o(off), .timer_pulse_i(tp), .ser_tx_data_i(sd),
    .ser_tx_frame_i(sf), .ser_tx_frame_oe_n_i(sfo), .timer_pulse_out_o(tpo),
    .timer_pulse_out_oe_n_o(tpo_oe_n), .ser_tx_data_o(sdo),
    .ser_tx_data_oe_n_o(sdo_oe_n), .ser_tx_frame_o(sfr),
    .ser_tx_frame_oe_n_o(sfr_oe_n));
  // Walk the controller with a tms pattern, lsb first
  task automatic nav(input logic [3:0] m, input int n);
    logic q;
    for (int i = 0; i < n; i++) emu_u.tick(m[i], 1'b0, q);
  endtask
  // Shift n bits, note each expected bit, then update and idle
  task automatic scan(input int n, input logic [31:0] d, e);
    logic q;
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(e[i]);
      emu_u.tick(i == n - 1, d[i], q);
    end
    nav(4'h1, 2);
  endtask
  // Compare each sampled bit that has a note waiting
  always @(emu_u.seen) begin
    if (exp_q.size() > 0) begin
      ev = exp_q.pop_front();
      `CHK(emu_u.bit_q, ev)
    end
  end
  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, far beyond the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fails++;
    stop_test;
  end
  initial begin
    void'($urandom(32'ha8d2));
    repeat (6) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    // Every mix of test reset and event pins; tck is ignored in reset
    for (int c = 0; c < 8; c++) begin
      {trst, e0_tb, e1_tb} <= c[2:0];
      {ce0, ce1, tp, sd, sf, sfo} <= 6'($urandom());
      if (c < 4) nav(4'($urandom()), 2);
      repeat (6) @(posedge sys_clk_i);
      `CHK(off, c == 2)
      `CHK(tpo_oe_n, c == 2)
      `CHK(tdo_oe_n, 1'b1)
      `CHK({tpo, sdo, sfr}, {tp, sd, sf})
      `CHK({sdo_oe_n, sfr_oe_n}, {c == 2, sfo | (c == 2)})
      `CHK({scan_ctl, ev1_rx}, {trst, trst & e1_tb})
      `CHK(ev0_rx, trst & e0_tb)
    end
    r = $urandom();
    cfg = {r[5:4], 2'b11};
    e0_tb <= r[0];
    repeat (6) @(posedge sys_clk_i);
    `CHK(ev0_rx, r[0])
    // Controller left reset with trst, so the id path is selected
    nav(4'h2, 4);
    scan(32, r, stp_pkg::ID_VAL);
    nav(4'h3, 4);
    scan(4, stp_pkg::INS_EMUCFG, stp_pkg::IR_RESET_VAL);
    for (int k = 0; k < 2; k++) begin
      nav(4'h2, 4);
      scan(4, cfg, k ? cfg : stp_pkg::CFG_RESET_VAL);
    end
    `CHK({e1_oe_n, e0_oe_n, e1, e0}, {2'b00, cfg[3:2] | {ce1, ce0}})
    nav(4'h3, 4);
    scan(4, stp_pkg::INS_BYPASS, stp_pkg::IR_RESET_VAL);
    nav(4'h2, 4);
    scan(2, r, {r[0], 1'b0});
    trst <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    `CHK(e1_oe_n, 1'b1)
    stop_test;
  end
endmodule
`default_nettype wire
